/* File: sbc_irq_pkg.sv */
package sbc_irq_pkg;

  // ==========================================================================
  // Frame layout
  // ==========================================================================
  localparam logic [4:0]  FRAME_BITS     = 5'h10;  // Clock edges per frame
  localparam logic [4:0]  COUNT_MAX      = 5'h1F;  // Edge counter saturates
  localparam logic [4:0]  RRS_EDGE       = 5'h03;  // Edge carrying bit 13
  localparam int          SEL_HI_POS     = 15;
  localparam int          SEL_LO_POS     = 14;
  localparam int          RRS_POS        = 13;
  localparam int          RO_POS         = 12;
  localparam logic [1:0]  SEL_ENABLE_REG = 2'h1;
  localparam logic [3:0]  REPLY_HEAD     = 4'h4;   // Bits 15..12 of replies

  // ==========================================================================
  // Enable and cause fields
  // ==========================================================================
  localparam int          WDOG_EN_POS    = 11;
  localparam int          TEMP_EN_POS    = 10;
  localparam int          GND_EN_POS     = 9;
  localparam int          CLKCNT_EN_POS  = 8;
  localparam int          RSVD_POS       = 7;
  localparam int          VFAIL_EN_POS   = 6;
  localparam logic [15:0] FIELD_MASK     = 16'h0F40;
  localparam logic [15:0] ENABLE_RESET   = 16'h0000;
  localparam logic [15:0] CAUSE_RESET    = 16'h0000;
  localparam logic [15:0] ONE_HOT_BASE   = 16'h0001;

  // Keep only the implemented enable or cause positions
  function automatic logic [15:0] field_bits(input logic [15:0] w);
    return w & FIELD_MASK;
  endfunction : field_bits

  // One-hot word for a field position
  function automatic logic [15:0] bit_at(input int pos);
    return ONE_HOT_BASE << pos;
  endfunction : bit_at

endpackage : sbc_irq_pkg

/* File: spi_frame_if.sv */
`timescale 1ns/1ns
interface spi_frame_if;
  logic [15:0] rx_word;     // Last received frame, link domain
  logic [4:0]  bit_count;   // Edges seen in the last frame
  logic        frame_tog;   // Flips at the first edge of each frame
  logic [15:0] fb_word;     // Enable feedback, held while a frame runs
  logic [15:0] cause_word;  // Cause snapshot, held while a frame runs

  modport link (
    output rx_word,
    output bit_count,
    output frame_tog,
    input  fb_word,
    input  cause_word
  );

  modport core (
    input  rx_word,
    input  bit_count,
    input  frame_tog,
    output fb_word,
    output cause_word
  );
endinterface : spi_frame_if

/* File: spi_frame_shifter.sv */
`timescale 1ns/1ns
module spi_frame_shifter
  import sbc_irq_pkg::*;
(
  // Link clock and clears
  input  wire logic  sck,
  input  wire logic  reset,
  input  wire logic  scs_n,
  // Serial data
  input  wire logic  sdi,
  output logic       sdo,
  // Words shared with the core domain
  spi_frame_if.link  frame
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [15:0] shift;
    logic [4:0]  count;
    logic        read_source_select;
    logic        tog;
  } frame_st_t;

  typedef struct packed {
    logic active;
    logic sdo;
  } edge_st_t;

  frame_st_t   fr_reg;
  frame_st_t   fr_next;
  edge_st_t    ed_reg;
  edge_st_t    ed_next;
  logic        frame_clr;
  logic [4:0]  count_new;

  // Reply bit for edge k; header bits first, then the selected word
  function automatic logic reply_bit(input logic [4:0]  k,
                                     input logic        read_source_select,
                                     input logic [15:0] cause,
                                     input logic [15:0] fb);
    logic [15:0] word;
    word = {REPLY_HEAD, (read_source_select ? cause[11:0] : fb[11:0])};
    if (k >= FRAME_BITS) begin
      return 1'b0;
    end
    return word[4'hF - k[3:0]];
  endfunction : reply_bit

  // Chip select high clears the frame flag, so each frame restarts at edge 1
  assign frame_clr = reset | scs_n;
  assign count_new = !ed_reg.active ? 5'h01 :
                     (fr_reg.count == COUNT_MAX) ? COUNT_MAX :
                     fr_reg.count + 5'h01;

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    fr_next       = fr_reg;
    ed_next       = ed_reg;
    fr_next.shift = {fr_reg.shift[14:0], sdi};
    fr_next.count = count_new;
    if (!ed_reg.active) begin
      fr_next.tog = ~fr_reg.tog;
    end
    // Read source is caught early so the reply can follow it
    if (count_new == RRS_EDGE) begin
      fr_next.read_source_select = sdi;
    end
    ed_next.active = 1'b1;
    ed_next.sdo    = reply_bit(count_new, fr_reg.read_source_select,
                               frame.cause_word, frame.fb_word);
  end

  // Frame contents survive chip select; the core reads them after it rises
  always_ff @(posedge sck or posedge reset) begin
    if (reset) begin
      fr_reg <= '0;
    end else begin
      fr_reg <= fr_next;
    end
  end

  // Cleared while deselected; first reply bit is the constant zero
  always_ff @(posedge sck or posedge frame_clr) begin
    if (frame_clr) begin
      ed_reg <= '0;
    end else begin
      ed_reg <= ed_next;
    end
  end

  assign sdo             = ed_reg.sdo;
  assign frame.rx_word   = fr_reg.shift;
  assign frame.bit_count = fr_reg.count;
  assign frame.frame_tog = fr_reg.tog;

endmodule : spi_frame_shifter

/* File: sbc_interrupt_enable_regs.sv */
`timescale 1ns/1ns
module sbc_interrupt_enable_regs
  import sbc_irq_pkg::*;
(
  // Core clock and reset
  input  wire logic  CORE_CLK,
  input  wire logic  RESET,
  // Serial link from the microcontroller
  input  wire logic  SPI_SCK,
  input  wire logic  SPI_CS_N,
  input  wire logic  SPI_SDI,
  output logic       SPI_SDO,
  output logic       SPI_SDO_OE,
  // Device mode
  input  wire logic  STANDBY_MODE,
  input  wire logic  STARTUP_RESTART_MODE,
  // Event sources inside the device
  input  wire logic  WDOG_OVERFLOW,
  input  wire logic  TEMP_WARNING,
  input  wire logic  GND_SHIFT_HIGH,
  input  wire logic  MAIN_REGULATOR_OK_FLAG,
  input  wire logic  BUS_REGULATOR_OK_FLAG,
  input  wire logic  AUX_REGULATOR_OK_FLAG,
  // Requests to the microcontroller and the reset logic
  output logic       IRQ_N,
  output logic       RESET_REQUEST
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic        cs_meta;
    logic        cs_sync;
    logic        cs_prev;
    logic        tog_meta;
    logic        tog_sync;
    logic        tog_seen;
    logic        primed;
    logic        temp_prev;
    logic        gnd_prev;
    logic [2:0]  reg_ok_prev;
    logic [15:0] enables;
    logic [15:0] cause;
    logic [15:0] fb_snap;
    logic [15:0] cause_snap;
    logic        irq_n;
    logic        reset_req;
  } core_st_t;

  core_st_t     st_reg;
  core_st_t     st_next;
  spi_frame_if  frame ();

  logic         frame_end;
  logic         frame_clocked;
  logic         frame_good;
  logic         reg_hit;
  logic         enable_write;
  logic         read_only_hit;
  logic         cause_read;
  logic         clk_fail;
  logic         clk_fail_irq;
  logic         clk_fail_reset;
  logic         wdog_irq;
  logic         wdog_reset;
  logic         temp_change;
  logic         gnd_change;
  logic         reg_fail;
  logic [2:0]   reg_ok_now;
  logic [15:0]  set_bits;
  logic [15:0]  read_clear;

  // ==========================================================================
  // Link side
  // ==========================================================================
  spi_frame_shifter u_shifter (
    .sck   (SPI_SCK),
    .reset (RESET),
    .scs_n (SPI_CS_N),
    .sdi   (SPI_SDI),
    .sdo   (SPI_SDO),
    .frame (frame)
  );

  // Drive the data line only while selected
  assign SPI_SDO_OE       = ~SPI_CS_N;
  // Snapshots stay still during a frame, so the link reads them safely
  assign frame.fb_word    = st_reg.fb_snap;
  assign frame.cause_word = st_reg.cause_snap;

  // ==========================================================================
  // Frame decode, done once chip select has risen
  // ==========================================================================
  // A frame with no edge leaves the toggle unchanged and counts as bad
  assign frame_end     = st_reg.cs_sync & ~st_reg.cs_prev;
  assign frame_clocked = st_reg.tog_sync ^ st_reg.tog_seen;
  assign frame_good    = frame_clocked &
                         (frame.bit_count == FRAME_BITS);
  assign reg_hit       = frame.rx_word[SEL_HI_POS:SEL_LO_POS]
                         == SEL_ENABLE_REG;
  assign enable_write  = frame_end & frame_good & reg_hit &
                         ~frame.rx_word[RO_POS];
  assign read_only_hit = frame_end & frame_good & reg_hit &
                         frame.rx_word[RO_POS];
  assign cause_read    = frame_end & frame_good & reg_hit &
                         frame.rx_word[RRS_POS];

  // Clock count failures: interrupt, reset, or silent drop
  assign clk_fail       = frame_end & ~frame_good;
  assign clk_fail_irq   = clk_fail & st_reg.enables[CLKCNT_EN_POS] &
                          ~STARTUP_RESTART_MODE;
  assign clk_fail_reset = clk_fail & st_reg.enables[CLKCNT_EN_POS] &
                          STARTUP_RESTART_MODE;

  // ==========================================================================
  // Event detection
  // ==========================================================================
  // Watchdog overflow outside the interrupt case always asks for reset
  assign wdog_irq   = WDOG_OVERFLOW & STANDBY_MODE &
                      st_reg.enables[WDOG_EN_POS];
  assign wdog_reset = WDOG_OVERFLOW & ~wdog_irq;

  // Primed flag masks the first cycle, which has no valid history
  assign reg_ok_now  = {AUX_REGULATOR_OK_FLAG, BUS_REGULATOR_OK_FLAG,
                        MAIN_REGULATOR_OK_FLAG};
  assign temp_change = st_reg.primed & (TEMP_WARNING ^ st_reg.temp_prev);
  assign gnd_change  = st_reg.primed & (GND_SHIFT_HIGH ^ st_reg.gnd_prev);
  assign reg_fail    = st_reg.primed &
                       (|(st_reg.reg_ok_prev & ~reg_ok_now));

  // Gather the cause bits raised this cycle
  always_comb begin
    set_bits = CAUSE_RESET;
    if (wdog_irq) begin
      set_bits = set_bits | bit_at(WDOG_EN_POS);
    end
    if (temp_change && st_reg.enables[TEMP_EN_POS]) begin
      set_bits = set_bits | bit_at(TEMP_EN_POS);
    end
    if (gnd_change && st_reg.enables[GND_EN_POS]) begin
      set_bits = set_bits | bit_at(GND_EN_POS);
    end
    if (clk_fail_irq) begin
      set_bits = set_bits | bit_at(CLKCNT_EN_POS);
    end
    if (reg_fail && st_reg.enables[VFAIL_EN_POS]) begin
      set_bits = set_bits | bit_at(VFAIL_EN_POS);
    end
  end

  // A cause read clears only what the host was shown
  assign read_clear = cause_read ? st_reg.cause_snap : CAUSE_RESET;

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    st_next             = st_reg;
    // Two-stage crossing of chip select and the frame toggle
    st_next.cs_meta     = SPI_CS_N;
    st_next.cs_sync     = st_reg.cs_meta;
    st_next.cs_prev     = st_reg.cs_sync;
    st_next.tog_meta    = frame.frame_tog;
    st_next.tog_sync    = st_reg.tog_meta;
    if (frame_end) begin
      st_next.tog_seen = st_reg.tog_sync;
    end
    st_next.primed      = 1'b1;
    st_next.temp_prev   = TEMP_WARNING;
    st_next.gnd_prev    = GND_SHIFT_HIGH;
    st_next.reg_ok_prev = reg_ok_now;

    // Bad-count frames never reach here, so they are dropped whole
    if (enable_write) begin
      // Reserved bit 7 falls outside the mask and reads back as zero
      st_next.enables = field_bits(frame.rx_word);
    end
    // Hardware clear beats a same-cycle write: fail-safe default
    if (WDOG_OVERFLOW) begin
      st_next.enables[WDOG_EN_POS] = 1'b0;
    end

    // New events win over the read clear, so none is lost
    st_next.cause = (st_reg.cause & ~read_clear) | set_bits;

    // Refresh the link-facing words only while deselected
    if (st_reg.cs_sync) begin
      st_next.fb_snap    = field_bits(st_reg.enables);
      st_next.cause_snap = st_reg.cause;
    end

    st_next.irq_n     = ~(|st_next.cause);
    st_next.reset_req = wdog_reset | clk_fail_reset;
  end

  // Synchronisers preset to the idle, deselected level
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      st_reg            <= '0;
      st_reg.cs_meta    <= 1'b1;
      st_reg.cs_sync    <= 1'b1;
      st_reg.cs_prev    <= 1'b1;
      st_reg.enables    <= ENABLE_RESET;
      st_reg.cause      <= CAUSE_RESET;
      st_reg.cause_snap <= CAUSE_RESET;
      st_reg.irq_n      <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign IRQ_N         = st_reg.irq_n;
  assign RESET_REQUEST = st_reg.reset_req;

  // ==========================================================================
  // Checks
  // ==========================================================================
  chk_other_addr: assert property (
    @(posedge CORE_CLK) disable iff (RESET)
    frame_end && frame_good && !reg_hit && !WDOG_OVERFLOW
    |=> $stable(st_reg.enables))
    else $error("enables changed on a frame for another register");

  chk_readonly_hold: assert property (
    @(posedge CORE_CLK) disable iff (RESET)
    read_only_hit && !WDOG_OVERFLOW |=> $stable(st_reg.enables))
    else $error("read-only frame changed the enables");

  chk_write_apply: assert property (
    @(posedge CORE_CLK) disable iff (RESET)
    enable_write && !WDOG_OVERFLOW
    |=> st_reg.enables == field_bits($past(frame.rx_word)))
    else $error("written enables do not match the frame");

  chk_feedback_view: assert property (
    @(posedge CORE_CLK) disable iff (RESET)
    enable_write && !WDOG_OVERFLOW && st_reg.cs_sync
    |=> ##1 st_reg.fb_snap == field_bits($past(frame.rx_word, 2)))
    else $error("feedback word does not show the written enables");

  chk_wdog_irq: assert property (
    @(posedge CORE_CLK) disable iff (RESET)
    WDOG_OVERFLOW && STANDBY_MODE && st_reg.enables[WDOG_EN_POS]
    |=> st_reg.cause[WDOG_EN_POS] && !RESET_REQUEST)
    else $error("standby overflow with enable did not interrupt");

  chk_wdog_reset: assert property (
    @(posedge CORE_CLK) disable iff (RESET)
    WDOG_OVERFLOW && !(STANDBY_MODE && st_reg.enables[WDOG_EN_POS])
    |=> RESET_REQUEST)
    else $error("overflow without interrupt enable did not reset");

  chk_wdog_autoclear: assert property (
    @(posedge CORE_CLK) disable iff (RESET)
    WDOG_OVERFLOW |=> !st_reg.enables[WDOG_EN_POS])
    else $error("watchdog enable survived an overflow");

  chk_temp_irq: assert property (
    @(posedge CORE_CLK) disable iff (RESET)
    temp_change && st_reg.enables[TEMP_EN_POS]
    |=> st_reg.cause[TEMP_EN_POS] && !IRQ_N)
    else $error("temperature change did not interrupt");

  chk_temp_quiet: assert property (
    @(posedge CORE_CLK) disable iff (RESET)
    $rose(st_reg.cause[TEMP_EN_POS]) |-> $past(st_reg.enables[TEMP_EN_POS]))
    else $error("temperature cause set while disabled");

  chk_gnd_irq: assert property (
    @(posedge CORE_CLK) disable iff (RESET)
    gnd_change && st_reg.enables[GND_EN_POS]
    |=> st_reg.cause[GND_EN_POS])
    else $error("ground shift change did not interrupt");

  chk_clk_fail_irq: assert property (
    @(posedge CORE_CLK) disable iff (RESET)
    clk_fail && st_reg.enables[CLKCNT_EN_POS] && !STARTUP_RESTART_MODE
    |=> st_reg.cause[CLKCNT_EN_POS])
    else $error("clock count failure did not interrupt");

  chk_clk_fail_reset: assert property (
    @(posedge CORE_CLK) disable iff (RESET)
    clk_fail && st_reg.enables[CLKCNT_EN_POS] && STARTUP_RESTART_MODE
    |=> RESET_REQUEST && !$rose(st_reg.cause[CLKCNT_EN_POS]))
    else $error("start-up clock count failure did not reset");

  chk_clk_fail_drop: assert property (
    @(posedge CORE_CLK) disable iff (RESET)
    clk_fail && !st_reg.enables[CLKCNT_EN_POS] && !WDOG_OVERFLOW
    |=> $stable(st_reg.enables) && !$rose(st_reg.cause[CLKCNT_EN_POS]))
    else $error("bad-count frame was not dropped");

  chk_volt_irq: assert property (
    @(posedge CORE_CLK) disable iff (RESET)
    reg_fail && st_reg.enables[VFAIL_EN_POS]
    |=> st_reg.cause[VFAIL_EN_POS])
    else $error("regulator flag clearing did not interrupt");

  chk_read_clear: assert property (
    @(posedge CORE_CLK) disable iff (RESET)
    cause_read && (set_bits == CAUSE_RESET)
    |=> (st_reg.cause & $past(st_reg.cause_snap)) == CAUSE_RESET)
    else $error("cause bits shown to the host were not cleared");

endmodule : sbc_interrupt_enable_regs

/* File: spi_host_model.sv */
`timescale 1ns/1ns
// ============================================================================
// Host side of the serial link
// ============================================================================
module spi_host_model (
  // Serial link pins
  output logic      sck,
  output logic      cs_n,
  output logic      sdi,
  input  wire logic sdo
);
  logic last_bit;

  // Idle pins; the link clock stands still outside frames
  initial begin
    sck      = 1'b0;
    cs_n     = 1'b1;
    sdi      = 1'b1;
    last_bit = 1'b0;
  end

  // One frame; a count other than 16 only when a test asks for it
  task automatic xfer(input logic [15:0] tx, input int edges,
                      output logic [15:0] rx);
    logic [15:0] word;
    word = tx & 16'hFF7F;
    rx   = 16'h0000;
    #37;
    cs_n = 1'b0;
    #300;
    rx[15] = sdo;
    for (int k = 0; k < edges; k++) begin
      sdi = (k < 16) ? word[15-k] : ~last_bit;
      #62;
      sck = 1'b1;
      #63;
      sck = 1'b0;
      // Sample on the falling edge, after the device moved its data
      if (k < 15) begin
        rx[14-k] = sdo;
      end
      last_bit = sdi;
    end
    #60;
    cs_n = 1'b1;
    // Released data line shows the inverse so stale bits never match
    sdi = ~last_bit;
    // Gap long enough for the core to take the frame
    #800;
  endtask : xfer
endmodule : spi_host_model

/* File: sbc_interrupt_enable_regs_test.sv */
`timescale 1ns/1ns
// ============================================================================
// Self-checking bench for the enable registers
// ============================================================================
module sbc_interrupt_enable_regs_test;
  logic        core_clk;
  logic        reset;
  logic        sck;
  logic        cs_n;
  logic        sdi;
  logic        sdo;
  logic        sdo_oe;
  logic        standby;
  logic        startup;
  logic        wdog;
  logic        temp;
  logic        gnd;
  logic        main_ok;
  logic        bus_ok;
  logic        aux_ok;
  logic        irq_n;
  logic        rst_req;
  logic [15:0] rx;
  logic [15:0] exp_cause [7];
  int          err_count;
  int          cmp_count;
  int          rr_cnt;
  int          rr_base;
  int          cycles;

  // ==========================================================================
  // Design, host model, clock
  // ==========================================================================
  sbc_interrupt_enable_regs u_dut (
    .CORE_CLK               (core_clk),
    .RESET                  (reset),
    .SPI_SCK                (sck),
    .SPI_CS_N               (cs_n),
    .SPI_SDI                (sdi),
    .SPI_SDO                (sdo),
    .SPI_SDO_OE             (sdo_oe),
    .STANDBY_MODE           (standby),
    .STARTUP_RESTART_MODE   (startup),
    .WDOG_OVERFLOW          (wdog),
    .TEMP_WARNING           (temp),
    .GND_SHIFT_HIGH         (gnd),
    .MAIN_REGULATOR_OK_FLAG (main_ok),
    .BUS_REGULATOR_OK_FLAG  (bus_ok),
    .AUX_REGULATOR_OK_FLAG  (aux_ok),
    .IRQ_N                  (irq_n),
    .RESET_REQUEST          (rst_req)
  );

  spi_host_model u_host (
    .sck  (sck),
    .cs_n (cs_n),
    .sdi  (sdi),
    .sdo  (sdo)
  );

  initial core_clk = 1'b0;
  always #50 core_clk = ~core_clk;

  // Reset requests counted so one-cycle pulses are never missed
  always @(posedge core_clk) begin
    cycles++;
    if (rst_req === 1'b1) begin
      rr_cnt++;
    end
    // Data enable follows the select pin; an unknown request is a fault
    cmp_count++;
    if (sdo_oe !== !cs_n || $isunknown(rst_req)) begin
      err_count++;
      $display("Error at %0t: data enable or reset request", $time);
    end
    if (cycles == 5000) begin
      err_count++;
      $display("Error at %0t: timeout", $time);
      report_and_stop();
    end
  end

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic frame(input logic [15:0] tx, input int edges);
    u_host.xfer(tx, edges, rx);
    @(negedge core_clk);
  endtask : frame

  // Full frame with a check of the reply word
  task automatic rd(input logic [15:0] tx, input logic [15:0] exp);
    frame(tx, 16);
    chk(rx, exp, "reply");
  endtask : rd

  task automatic irq_is(input logic lvl);
    chk({15'h0000, irq_n}, {15'h0000, lvl}, "interrupt line");
  endtask : irq_is

  task automatic rr_is(input int n);
    chk(16'(rr_cnt - rr_base), 16'(n), "reset requests");
  endtask : rr_is

  task automatic wdog_pulse;
    @(negedge core_clk);
    wdog = 1'b1;
    @(negedge core_clk);
    wdog = 1'b0;
    repeat (3) @(negedge core_clk);
  endtask : wdog_pulse

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    err_count = 0;
    cmp_count = 0;
    rr_cnt    = 0;
    cycles    = 0;
    reset     = 1'b1;
    standby   = 1'b0;
    startup   = 1'b0;
    wdog      = 1'b0;
    temp      = 1'b0;
    gnd       = 1'b0;
    main_ok   = 1'b1;
    bus_ok    = 1'b1;
    aux_ok    = 1'b1;
    exp_cause = '{16'h4400, 16'h4200, 16'h4040, 16'h4040, 16'h4040,
                  16'h4400, 16'h4200};
    repeat (12) @(posedge core_clk);
    @(negedge core_clk);
    reset = 1'b0;
    repeat (4) @(negedge core_clk);
    rr_base = rr_cnt;

    // Idle state and enable writes, read-only and foreign address
    irq_is(1'b1);
    rd(16'h5000, 16'h4000);
    rd(16'h4F40, 16'h4000);
    rd(16'h5000, 16'h4F40);
    rd(16'h5E00, 16'h4F40);
    rd(16'h5000, 16'h4F40);
    frame(16'h8000, 16);
    rd(16'h5000, 16'h4F40);
    $display("Test register access done");

    // Temperature, ground shift and each regulator event in turn, both directions for temperature and ground shift, then cause read
    for (int i = 0; i < 7; i++) begin
      case (i)
        0: temp = 1'b1;
        1: gnd = 1'b1;
        2: main_ok = 1'b0;
        3: bus_ok = 1'b0;
        4: aux_ok = 1'b0;
        5: temp = 1'b0;
        default: gnd = 1'b0;
      endcase
      repeat (3) @(negedge core_clk);
      irq_is(1'b0);
      rd(16'h7000, exp_cause[i]);
      irq_is(1'b1);
    end
    main_ok = 1'b1;
    bus_ok  = 1'b1;
    aux_ok  = 1'b1;
    $display("Test enabled events done");

    // Temperature, ground shift and main regulator events with enables cleared
    rd(16'h4000, 16'h4F40);
    temp    = 1'b1;
    gnd     = 1'b1;
    main_ok = 1'b0;
    repeat (3) @(negedge core_clk);
    irq_is(1'b1);
    rd(16'h7000, 16'h4000);
    main_ok = 1'b1;
    $display("Test disabled events done");

    // Watchdog overflow: interrupt in standby with the enable set, reset otherwise
    rd(16'h4800, 16'h4000);
    standby = 1'b1;
    wdog_pulse();
    rr_is(0);
    irq_is(1'b0);
    rd(16'h5000, 16'h4000);
    rd(16'h7000, 16'h4800);
    wdog_pulse();
    rr_is(1);
    standby = 1'b0;
    rd(16'h4800, 16'h4000);
    wdog_pulse();
    rr_is(2);
    rd(16'h5000, 16'h4000);
    irq_is(1'b1);
    $display("Test watchdog done");

    // Clock count failures, enabled and disabled
    rd(16'h4100, 16'h4000);
    frame(16'h5000, 15);
    irq_is(1'b0);
    rd(16'h7000, 16'h4100);
    startup = 1'b1;
    frame(16'h5000, 17);
    rr_is(3);
    irq_is(1'b1);
    startup = 1'b0;
    rd(16'h4000, 16'h4100);
    frame(16'h4F40, 15);
    irq_is(1'b1);
    frame(16'h4F40, 0);
    frame(16'h4F40, 17);
    rd(16'h5000, 16'h4000);
    rr_is(3);
    $display("Test clock count done");

    report_and_stop();
  end
endmodule : sbc_interrupt_enable_regs_test
